//--- hdl/clge_engine.sv
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "clge_cfg.svh"

module clge_engine #(
  parameter int unsigned PLC_CYCLE_CLKS = `CLGE_PLC_CYCLE_CLKS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // AXI4-Lite write address
  input wire clge_pkg::clge_axi_addr_t s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire clge_pkg::clge_axi_addr_t s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import clge_pkg::*;

  // ==========================================
  // Storage
  clge_word_t poolMem [`CLGE_POOL_WORDS];
  logic [31:0] cfgMem [`CLGE_CFG_WORDS];
  clge_word_t extReg [`CLGE_EXT_WORDS];
  logic ffPrevSet [24];
  logic ffPrevClk [24];
  logic tmPrev [`CLGE_GROUPS];
  logic [31:0] tmRem [`CLGE_GROUPS];

  // Out-of-range pool selectors read as zero
  function automatic clge_word_t poolRd(input clge_sig_t s);
    poolRd = (s < 9'(`CLGE_POOL_WORDS)) ? poolMem[s] : 16'h0000;
  endfunction

  // One-bit view of a pool word; 1-bit inputs use bit 0
  function automatic logic poolBit(input clge_sig_t s);
    clge_word_t w;
    w = poolRd(s);
    poolBit = w[0];
  endfunction

  // Two-input element; undefined codes give zero
  function automatic logic gateOp(input logic [2:0] op, input logic a,
                                  input logic b);
    case (op)
      3'h0: gateOp = a & b;
      3'h1: gateOp = a | b;
      3'h2: gateOp = a ^ b;
      3'h3: gateOp = ~(a & b);
      3'h4: gateOp = ~(a | b);
      3'h5: gateOp = ~(a ^ b);
      default: gateOp = 1'b0;
    endcase
  endfunction

  // Time base in PLC passes; unknown codes fall back to the shortest
  function automatic logic [31:0] tbPasses(input logic [2:0] code);
    case (code)
      3'h1: tbPasses = 32'(`CLGE_TB1_MS / `CLGE_PLC_CYCLE_MS);
      3'h2: tbPasses = 32'(`CLGE_TB2_MS / `CLGE_PLC_CYCLE_MS);
      3'h3: tbPasses = 32'(`CLGE_TB3_MS / `CLGE_PLC_CYCLE_MS);
      3'h4: tbPasses = 32'(`CLGE_TB4_MS / `CLGE_PLC_CYCLE_MS);
      default: tbPasses = 32'(`CLGE_TB0_MS / `CLGE_PLC_CYCLE_MS);
    endcase
  endfunction

  // Merge written bytes into an old word
  function automatic logic [31:0] strbMerge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      strbMerge[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  // ==========================================
  // PLC cycle tick
  logic [31:0] tickCnt_ff, nxt_tickCnt;
  logic tick_ff, nxt_tick;

  // Free-running, so pass starts stay on a fixed 20 ms grid
  always_comb begin
    nxt_tick = 1'b0;
    nxt_tickCnt = tickCnt_ff + 32'h00000001;
    if (tickCnt_ff >= PLC_CYCLE_CLKS - 1) begin
      nxt_tickCnt = 32'h00000000;
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tickCnt_ff <= 32'h00000000;
      tick_ff <= 1'b0;
    end else begin
      tickCnt_ff <= nxt_tickCnt;
      tick_ff <= nxt_tick;
    end
  end

  // ==========================================
  // Block evaluation for the current group and index
  clge_state_t state_ff, nxt_state;
  logic [3:0] grp_ff, nxt_grp;
  logic [2:0] idx_ff, nxt_idx;
  logic [31:0] passCnt_ff, nxt_passCnt;
  logic runEn_ff, nxt_runEn;
  clge_sig_t base;
  logic [4:0] ffSlot;
  logic [31:0] lbW0, lbW1, ffW, tmW;
  logic lbX, lbY, lbRes;
  clge_word_t ffData, ffCur, ffNew;
  logic ffClk, ffSet, ffSetEv, ffRstEv, ffEdge;
  logic tmSet, tmRst, tmTrig;
  logic [31:0] tmLoad, tmNew;

  assign base = 9'(`CLGE_EXT_WORDS) + 9'(grp_ff) * 9'(`CLGE_GRP_WORDS);
  assign ffSlot = {grp_ff, idx_ff[0]};

  always_comb begin
    lbW0 = cfgMem[{grp_ff, 1'b0, idx_ff, 1'b0}];
    lbW1 = cfgMem[{grp_ff, 1'b0, idx_ff, 1'b1}];
    // x on inputs 1/2, y on 3/4, z on x and y
    lbX = gateOp(lbW0[`CLGE_F_OPX], poolBit(lbW0[`CLGE_F_SELA]),
                 poolBit(lbW0[`CLGE_F_SELB]));
    lbY = gateOp(lbW0[`CLGE_F_OPY], poolBit(lbW1[`CLGE_F_SELA]),
                 poolBit(lbW1[`CLGE_F_SELB]));
    lbRes = gateOp({1'b0, lbW1[`CLGE_F_OPZ]}, lbX, lbY);
    // Storage element; reset dominates set when both act
    ffW = cfgMem[{grp_ff, 4'h8, idx_ff[0]}];
    ffData = poolRd(ffW[`CLGE_F_SELA]);
    ffClk = poolBit(ffW[`CLGE_F_SELB]);
    ffSet = |ffData;
    ffCur = poolMem[base + 9'(`CLGE_SLOT_FF) + 9'(idx_ff[0])];
    ffEdge = ffW[`CLGE_F_EVAL] ? (ffPrevClk[ffSlot] & ~ffClk)
                               : (~ffPrevClk[ffSlot] & ffClk);
    ffSetEv = ffW[`CLGE_F_EVAL] ? (ffSet & ~ffPrevSet[ffSlot]) : ffSet;
    ffRstEv = ffW[`CLGE_F_EVAL] ? (ffClk & ~ffPrevClk[ffSlot]) : ffClk;
    if (ffW[`CLGE_F_MODE]) begin
      ffNew = ffEdge ? ffData : ffCur;
    end else if (ffRstEv) begin
      ffNew = 16'h0000;
    end else if (ffSetEv) begin
      ffNew = 16'h0001;
    end else begin
      ffNew = ffCur;
    end
    // Monoflop timer, counted in PLC passes
    tmW = cfgMem[{grp_ff, 5'(`CLGE_CW_TMR)}];
    tmSet = poolBit(tmW[`CLGE_F_SELA]);
    tmRst = poolBit(tmW[`CLGE_F_SELB]);
    tmLoad = 32'(cfgMem[{grp_ff, 5'(`CLGE_CW_TIME)}][`CLGE_F_VAL])
             * tbPasses(tmW[`CLGE_F_BASE]);
    if (!tmW[`CLGE_F_MODE]) begin
      tmTrig = tmSet;
    end else if (tmW[`CLGE_F_EVAL]) begin
      tmTrig = tmPrev[grp_ff] & ~tmSet;
    end else begin
      tmTrig = ~tmPrev[grp_ff] & tmSet;
    end
    if (tmRst) begin
      tmNew = 32'h00000000;
    end else if (tmTrig && (tmRem[grp_ff] == 32'h00000000 ||
                            tmW[`CLGE_F_RETRIG])) begin
      tmNew = tmLoad;
    end else if (tmRem[grp_ff] != 32'h00000000) begin
      tmNew = tmRem[grp_ff] - 32'h00000001;
    end else begin
      tmNew = 32'h00000000;
    end
  end

  // ==========================================
  // Pass sequencer
  logic pWe, ffWe, tmWe, freezeEn;
  clge_sig_t pA0, pA1;
  clge_word_t pD0, pD1;

  // Threshold, hysteresis, counter and value-table stages are not built
  // here, and the state sequence keeps no slots for them in the order
  always_comb begin
    nxt_state = state_ff;
    nxt_grp = grp_ff;
    nxt_idx = idx_ff;
    nxt_passCnt = passCnt_ff;
    pWe = 1'b0;
    ffWe = 1'b0;
    tmWe = 1'b0;
    freezeEn = 1'b0;
    pA0 = base;
    pA1 = base;
    pD0 = 16'h0000;
    pD1 = 16'h0000;
    unique case (state_ff)
      S_IDLE: begin
        if (tick_ff && runEn_ff) begin
          nxt_state = S_FREEZE;
        end
      end
      S_FREEZE: begin
        freezeEn = 1'b1;
        nxt_grp = 4'h0;
        nxt_idx = 3'h0;
        nxt_state = S_CONST;
      end
      S_CONST: begin
        pWe = 1'b1;
        pA0 = base + 9'(`CLGE_SLOT_CONST) + 9'(idx_ff);
        pA1 = pA0;
        pD0 = cfgMem[{grp_ff, 5'(`CLGE_CW_CONST) + 5'(idx_ff)}][15:0];
        pD1 = pD0;
        nxt_idx = idx_ff + 3'h1;
        if (idx_ff == 3'h4) begin
          nxt_idx = 3'h0;
          nxt_state = S_FF;
        end
      end
      S_FF: begin
        pWe = 1'b1;
        ffWe = 1'b1;
        pA0 = base + 9'(`CLGE_SLOT_FF) + 9'(idx_ff[0]);
        pA1 = base + 9'(`CLGE_SLOT_FFN) + 9'(idx_ff[0]);
        pD0 = ffNew;
        pD1 = {15'h0000, ~|ffNew};
        nxt_idx = 3'h1;
        if (idx_ff[0]) begin
          nxt_idx = 3'h0;
          nxt_state = S_TMR;
        end
      end
      S_TMR: begin
        pWe = 1'b1;
        tmWe = 1'b1;
        pA0 = base + 9'(`CLGE_SLOT_TMR);
        pA1 = base + 9'(`CLGE_SLOT_TMRN);
        pD0 = {15'h0000, |tmNew};
        pD1 = {15'h0000, ~|tmNew};
        nxt_state = S_LOGIC;
      end
      S_LOGIC: begin
        pWe = 1'b1;
        pA0 = base + 9'(idx_ff);
        pA1 = base + 9'(`CLGE_SLOT_LBN) + 9'(idx_ff);
        pD0 = {15'h0000, lbRes};
        pD1 = {15'h0000, ~lbRes};
        nxt_idx = idx_ff + 3'h1;
        if (idx_ff == 3'h7) begin
          nxt_idx = 3'h0;
          if (grp_ff == 4'(`CLGE_GROUPS - 1)) begin
            nxt_state = S_IDLE;
            nxt_passCnt = passCnt_ff + 32'h00000001;
          end else begin
            nxt_grp = grp_ff + 4'h1;
            nxt_state = S_CONST;
          end
        end
      end
      default: nxt_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= S_IDLE;
      grp_ff <= 4'h0;
      idx_ff <= 3'h0;
      passCnt_ff <= 32'h00000000;
    end else begin
      state_ff <= nxt_state;
      grp_ff <= nxt_grp;
      idx_ff <= nxt_idx;
      passCnt_ff <= nxt_passCnt;
    end
  end

  // Pool and block history; a result written here is read by the next
  // block, while earlier readers already saw the previous pass
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < `CLGE_POOL_WORDS; i++) begin
        poolMem[i] <= 16'h0000;
      end
      for (int i = 0; i < 24; i++) begin
        ffPrevSet[i] <= 1'b0;
        ffPrevClk[i] <= 1'b0;
      end
      for (int i = 0; i < `CLGE_GROUPS; i++) begin
        tmPrev[i] <= 1'b0;
        tmRem[i] <= 32'h00000000;
      end
    end else begin
      if (freezeEn) begin
        for (int i = 0; i < `CLGE_EXT_WORDS; i++) begin
          poolMem[i] <= extReg[i];
        end
      end
      if (pWe) begin
        poolMem[pA0] <= pD0;
        poolMem[pA1] <= pD1;
      end
      if (ffWe) begin
        ffPrevSet[ffSlot] <= ffSet;
        ffPrevClk[ffSlot] <= ffClk;
      end
      if (tmWe) begin
        tmPrev[grp_ff] <= tmSet;
        tmRem[grp_ff] <= tmNew;
      end
    end
  end

  // ==========================================
  // AXI4-Lite write channel
  logic awHeld_ff, nxt_awHeld, wHeld_ff, nxt_wHeld;
  logic awReady_ff, nxt_awReady, wReady_ff, nxt_wReady;
  logic bValid_ff, nxt_bValid;
  logic [1:0] bResp_ff, nxt_bResp;
  clge_axi_addr_t awAddr_ff, nxt_awAddr;
  logic [31:0] wData_ff, nxt_wData;
  logic [3:0] wStrb_ff, nxt_wStrb;
  logic doWr, cfgWe, extWe, ctrlWe;

  // Address and data are held separately so either may come first
  always_comb begin
    nxt_awHeld = awHeld_ff | (s_axi_awvalid & awReady_ff);
    nxt_awAddr = (s_axi_awvalid & awReady_ff) ? s_axi_awaddr : awAddr_ff;
    nxt_wHeld = wHeld_ff | (s_axi_wvalid & wReady_ff);
    nxt_wData = (s_axi_wvalid & wReady_ff) ? s_axi_wdata : wData_ff;
    nxt_wStrb = (s_axi_wvalid & wReady_ff) ? s_axi_wstrb : wStrb_ff;
    nxt_bValid = bValid_ff & ~s_axi_bready;
    nxt_bResp = bResp_ff;
    doWr = awHeld_ff & wHeld_ff & ~bValid_ff;
    cfgWe = doWr && awAddr_ff < `CLGE_ADDR_CFG_END;
    extWe = doWr && awAddr_ff[12:5] == `CLGE_ADDR_EXT >> 5;
    ctrlWe = doWr && awAddr_ff[12:2] == `CLGE_ADDR_CTRL >> 2;
    nxt_runEn = (ctrlWe && wStrb_ff[0]) ? wData_ff[0] : runEn_ff;
    if (doWr) begin
      nxt_awHeld = 1'b0;
      nxt_wHeld = 1'b0;
      nxt_bValid = 1'b1;
      nxt_bResp = (cfgWe | extWe | ctrlWe) ? `CLGE_RESP_OKAY
                                           : `CLGE_RESP_SLVERR;
    end
    nxt_awReady = ~nxt_awHeld;
    nxt_wReady = ~nxt_wHeld;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      awHeld_ff <= 1'b0;
      wHeld_ff <= 1'b0;
      awReady_ff <= 1'b0;
      wReady_ff <= 1'b0;
      bValid_ff <= 1'b0;
      bResp_ff <= `CLGE_RESP_OKAY;
      awAddr_ff <= 13'h0000;
      wData_ff <= 32'h00000000;
      wStrb_ff <= 4'h0;
      runEn_ff <= `CLGE_CTRL_RST;
    end else begin
      awHeld_ff <= nxt_awHeld;
      wHeld_ff <= nxt_wHeld;
      awReady_ff <= nxt_awReady;
      wReady_ff <= nxt_wReady;
      bValid_ff <= nxt_bValid;
      bResp_ff <= nxt_bResp;
      awAddr_ff <= nxt_awAddr;
      wData_ff <= nxt_wData;
      wStrb_ff <= nxt_wStrb;
      runEn_ff <= nxt_runEn;
    end
  end

  // Configuration may change mid-pass; blocks then mix old and new setup
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < `CLGE_CFG_WORDS; i++) begin
        cfgMem[i] <= 32'h00000000;
      end
      for (int i = 0; i < `CLGE_EXT_WORDS; i++) begin
        extReg[i] <= 16'h0000;
      end
    end else begin
      if (cfgWe) begin
        cfgMem[awAddr_ff[10:2]] <= strbMerge(cfgMem[awAddr_ff[10:2]],
                                             wData_ff, wStrb_ff);
      end
      if (extWe) begin
        extReg[awAddr_ff[4:2]] <= 16'(strbMerge({16'h0000,
          extReg[awAddr_ff[4:2]]}, wData_ff, wStrb_ff));
      end
    end
  end

  // ==========================================
  // AXI4-Lite read channel
  logic arReady_ff, nxt_arReady, rValid_ff, nxt_rValid;
  logic [31:0] rData_ff, nxt_rData, rdVal;
  logic [1:0] rResp_ff, nxt_rResp, rdResp;

  // Pool window at 0x1000 shows live block results
  always_comb begin
    rdVal = 32'h00000000;
    rdResp = `CLGE_RESP_OKAY;
    if (s_axi_araddr < `CLGE_ADDR_CFG_END) begin
      rdVal = cfgMem[s_axi_araddr[10:2]];
    end else if (s_axi_araddr[12:5] == `CLGE_ADDR_EXT >> 5) begin
      rdVal = {16'h0000, extReg[s_axi_araddr[4:2]]};
    end else if (s_axi_araddr[12:2] == `CLGE_ADDR_CTRL >> 2) begin
      rdVal = {31'h0, runEn_ff};
    end else if (s_axi_araddr[12:2] == `CLGE_ADDR_STAT >> 2) begin
      rdVal = {31'h0, state_ff != S_IDLE};
    end else if (s_axi_araddr[12:2] == `CLGE_ADDR_PASS >> 2) begin
      rdVal = passCnt_ff;
    end else if (s_axi_araddr[12:11] == 2'h2 &&
                 s_axi_araddr[10:2] < 9'(`CLGE_POOL_WORDS)) begin
      rdVal = {16'h0000, poolMem[s_axi_araddr[10:2]]};
    end else begin
      rdResp = `CLGE_RESP_SLVERR;
    end
    nxt_arReady = arReady_ff;
    nxt_rValid = rValid_ff;
    nxt_rData = rData_ff;
    nxt_rResp = rResp_ff;
    if (s_axi_arvalid && arReady_ff) begin
      nxt_arReady = 1'b0;
      nxt_rValid = 1'b1;
      nxt_rData = rdVal;
      nxt_rResp = rdResp;
    end else if (rValid_ff && s_axi_rready) begin
      nxt_rValid = 1'b0;
      nxt_arReady = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      arReady_ff <= 1'b1;
      rValid_ff <= 1'b0;
      rData_ff <= 32'h00000000;
      rResp_ff <= `CLGE_RESP_OKAY;
    end else begin
      arReady_ff <= nxt_arReady;
      rValid_ff <= nxt_rValid;
      rData_ff <= nxt_rData;
      rResp_ff <= nxt_rResp;
    end
  end

  // Outputs straight from flops
  assign s_axi_awready = awReady_ff;
  assign s_axi_wready = wReady_ff;
  assign s_axi_bvalid = bValid_ff;
  assign s_axi_bresp = bResp_ff;
  assign s_axi_arready = arReady_ff;
  assign s_axi_rvalid = rValid_ff;
  assign s_axi_rdata = rData_ff;
  assign s_axi_rresp = rResp_ff;
endmodule

//--- include/clge_cfg.svh
`ifndef CLGE_CFG_SVH
`define CLGE_CFG_SVH
// ==========================================
// Timing
`define CLGE_CLK_PERIOD_NS 20
`define CLGE_PLC_CYCLE_MS 20
`define CLGE_PLC_CYCLE_CLKS \
  ((`CLGE_PLC_CYCLE_MS * 1000000) / `CLGE_CLK_PERIOD_NS)
`define CLGE_TB0_MS 100
`define CLGE_TB1_MS 1000
`define CLGE_TB2_MS 10000
`define CLGE_TB3_MS 60000
`define CLGE_TB4_MS 600000
// ==========================================
// Signal pool layout
`define CLGE_GROUPS 12
`define CLGE_EXT_WORDS 8
`define CLGE_GRP_WORDS 27
`define CLGE_POOL_WORDS 332
`define CLGE_SLOT_LBN 8
`define CLGE_SLOT_FF 16
`define CLGE_SLOT_FFN 18
`define CLGE_SLOT_TMR 20
`define CLGE_SLOT_TMRN 21
`define CLGE_SLOT_CONST 22
// ==========================================
// Per-group configuration words and fields
`define CLGE_CFG_WORDS 384
`define CLGE_CW_TMR 18
`define CLGE_CW_TIME 19
`define CLGE_CW_CONST 20
`define CLGE_F_SELA 8:0
`define CLGE_F_SELB 24:16
`define CLGE_F_OPX 27:25
`define CLGE_F_OPY 30:28
`define CLGE_F_OPZ 26:25
`define CLGE_F_MODE 25
`define CLGE_F_EVAL 26
`define CLGE_F_RETRIG 27
`define CLGE_F_BASE 30:28
`define CLGE_F_VAL 15:0
// ==========================================
// Register map (byte addresses)
`define CLGE_ADDR_CFG_END 13'h0600
`define CLGE_ADDR_EXT 13'h0800
`define CLGE_ADDR_CTRL 13'h0820
`define CLGE_ADDR_STAT 13'h0824
`define CLGE_ADDR_PASS 13'h0828
`define CLGE_CTRL_RST 1'b0
`define CLGE_RESP_OKAY 2'h0
`define CLGE_RESP_SLVERR 2'h2
`endif

//--- include/clge_pkg.sv
package clge_pkg;
  // Sequencer states of one evaluation pass
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_FREEZE = 3'h1,
    S_CONST = 3'h2,
    S_FF = 3'h3,
    S_TMR = 3'h4,
    S_LOGIC = 3'h5
  } clge_state_t;
  typedef logic [8:0] clge_sig_t;
  typedef logic [15:0] clge_word_t;
  typedef logic [12:0] clge_axi_addr_t;
endpackage

//--- testbench/clge_engine_asserts.sv
`timescale 1ns/1ps
// ==========================================
// Bus checks at the engine's ports
module clge_engine_asserts #(
  parameter int unsigned PLC_CYCLE_CLKS = 400
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Write channels
  input wire clge_pkg::clge_axi_addr_t s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read channels
  input wire clge_pkg::clge_axi_addr_t s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import clge_pkg::*;
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  // Answers stand unchanged until taken
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  // Answer latency after the handshakes
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("no write answer");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("no read answer");
  // One transfer at a time per direction
  a_read_single: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready while read open");
  a_aw_busy: assert property (s_axi_awvalid && s_axi_awready
    |=> !s_axi_awready) else $error("awready stayed high");
  a_w_busy: assert property (s_axi_wvalid && s_axi_wready
    |=> !s_axi_wready) else $error("wready stayed high");
  // Quiet bus right after reset; refused reads carry zero
  a_release_quiet: assert property ($fell(reset)
    |-> !s_axi_bvalid && !s_axi_rvalid && !s_axi_awready)
    else $error("bus busy after reset");
  a_refused_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2
    |-> s_axi_rdata == 32'h0) else $error("refused read carries data");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  c_write_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

//--- testbench/clge_axi_master.sv
`timescale 1ns/1ps
// ==========================================
// Software side: single-beat bus master
module clge_axi_master (
  // Clock
  input wire logic clk,
  // Write channels
  output clge_pkg::clge_axi_addr_t s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // Read channels
  output clge_pkg::clge_axi_addr_t s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready,
  // Raised when an answer never comes
  output logic hung
);
  import clge_pkg::*;
  // Idle bus at time zero
  initial {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb,
    s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid,
    s_axi_rready, hung} = '0;
  // Random idle gap so the slave sees slow and prompt masters
  task automatic wr(input clge_axi_addr_t a, input logic [31:0] d);
    int n = 0;
    bit awDone = 0;
    bit wDone = 0;
    repeat ($urandom_range(2)) @(posedge clk);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(awDone && wDone) && n < 50) begin
      @(posedge clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) begin
        awDone = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wDone = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge clk);
      n++;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    if (n >= 50) hung <= 1'b1;
  endtask
  // Read: address held until taken, rready held until rvalid
  task automatic rd(input clge_axi_addr_t a, output logic [31:0] d);
    int n = 0;
    repeat ($urandom_range(2)) @(posedge clk);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (!s_axi_arready && n < 50);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (!s_axi_rvalid && n < 50);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    if (n >= 50) hung <= 1'b1;
  endtask
endmodule

//--- testbench/configurable_logic_group_engine_tb.sv
`timescale 1ns/1ps
`include "clge_cfg.svh"
module configurable_logic_group_engine_tb;
  import clge_pkg::*;
  localparam int unsigned CYC = 400;
  localparam clge_axi_addr_t POOL = 13'h1000;
  logic clk = 0;
  logic reset = 1;
  clge_axi_addr_t s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, hung;
  logic [31:0] s_axi_wdata, s_axi_rdata, d1, d2;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] ext[4];
  logic [34:0] rdQ[$];
  logic [2:0] wrQ[$];
  int n_fail = 0;
  int comparisons = 0;
  // ==========================================
  // Design, master and clock
  clge_engine #(.PLC_CYCLE_CLKS(CYC)) dut (.clk, .reset, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  clge_axi_master bfm (.clk, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .hung);
  initial forever #10 clk = ~clk;
  // ==========================================
  // Helpers
  task automatic check(input string what, input logic [34:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input clge_axi_addr_t a, input logic [31:0] d,
    input logic [1:0] r = 2'h0);
    wrQ.push_back({1'b1, r});
    bfm.wr(a, d);
  endtask
  task automatic rd(input clge_axi_addr_t a, input logic [31:0] e,
    input logic [1:0] r = 2'h0, output logic [31:0] d);
    rdQ.push_back({1'b1, r, e});
    bfm.rd(a, d);
  endtask
  task automatic peek(input clge_axi_addr_t a, output logic [31:0] d);
    rdQ.push_back(35'h0);
    bfm.rd(a, d);
  endtask
  task automatic pool(input int i, input logic [31:0] e);
    logic [31:0] d;
    rd(POOL + 13'(4 * i), e, 2'h0, d);
  endtask
  task automatic setx(input int i, input logic [15:0] v);
    wr(13'(`CLGE_ADDR_EXT + 4 * i), {16'h0, v});
  endtask
  // One pass: run until the pass count moves, then stop
  task automatic run_pass();
    logic [31:0] p0, p;
    int n = 0;
    peek(`CLGE_ADDR_PASS, p0);
    wr(`CLGE_ADDR_CTRL, 32'h1);
    p = p0;
    while (p === p0 && n < 400) begin
      peek(`CLGE_ADDR_PASS, p);
      n++;
    end
    wr(`CLGE_ADDR_CTRL, 32'h0);
    check("pass count", {3'h0, p}, {3'h0, p0 + 32'h1});
    rd(`CLGE_ADDR_STAT, 32'h0, 2'h0, p);
  endtask
  function automatic logic op(input int c, input logic a, b);
    case (c)
      0: op = a & b;
      1: op = a | b;
      2: op = a ^ b;
      3: op = ~(a & b);
      4: op = ~(a | b);
      5: op = ~(a ^ b);
      default: op = 1'b0;
    endcase
  endfunction
  // ==========================================
  // Watcher: oldest note against each answer
  always @(posedge clk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      if (rdQ.size() == 0) check("read note", 35'h0, 35'h1);
      else if (rdQ[0][34]) check("read", {1'b1, s_axi_rresp, s_axi_rdata},
        rdQ.pop_front());
      else void'(rdQ.pop_front());
    end
    if (s_axi_bvalid && s_axi_bready) begin
      if (wrQ.size() == 0) check("write note", 35'h0, 35'h1);
      else check("bresp", {32'h0, 1'b1, s_axi_bresp}, {32'h0, wrQ.pop_front()});
    end
  end
  // Hang guards end the run through the same report
  always @(posedge hung) begin
    n_fail++;
    close_out();
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    close_out();
  end
  // ==========================================
  // Scenarios
  initial begin
    logic r;
    logic r0;
    void'($urandom(32'hABA0ED13));
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    rd(`CLGE_ADDR_CTRL, 32'h0, 2'h0, d1);
    rd(`CLGE_ADDR_PASS, 32'h0, 2'h0, d1);
    rd(13'h1800, 32'h0, `CLGE_RESP_SLVERR, d1);
    wr(`CLGE_ADDR_STAT, 32'h1, `CLGE_RESP_SLVERR);
    // Group 0 gates cover x and y codes 0 to 5 and z codes 0 to 2
    for (int k = 0; k < 8; k++) begin
      wr(13'(8 * k), {1'b0, 3'(k % 6), 3'((k + 2) % 6), 9'h1, 7'h0, 9'h0});
      wr(13'(8 * k + 4), {5'h0, 2'(k % 3), 9'h3, 7'h0, 9'h2});
    end
    // Group 1 gate 0 repeats group 0 gate 0 within the same pass
    wr(13'h80, {1'b0, 3'h0, 3'h0, 9'h8, 7'h0, 9'h8});
    wr(13'h84, {5'h0, 2'h0, 9'h8, 7'h0, 9'h8});
    repeat (3) begin
      for (int i = 0; i < 4; i++) begin
        ext[i] = 16'($urandom()) | 16'h8000;
        setx(i, ext[i]);
      end
      run_pass();
      for (int k = 0; k < 8; k++) begin
        r = op(k % 3, op((k + 2) % 6, ext[0][0], ext[1][0]),
          op(k % 6, ext[2][0], ext[3][0]));
        if (k == 0) r0 = r;
        pool(8 + k, {31'h0, r});
        pool(16 + k, {31'h0, ~r});
      end
      pool(35, {31'h0, r0});
      pool(24, {31'h0, ~ext[0][0]});
    end
    // Storage 0 as rising-edge latch, timer on rising edge, 5 passes
    wr(13'd64, {5'h0, 1'b0, 1'b1, 9'h5, 7'h0, 9'h4});
    wr(13'd72, {1'b0, 3'h0, 1'b0, 1'b0, 1'b1, 9'h7, 7'h0, 9'h6});
    wr(13'd76, 32'h1);
    d1 = {16'h0, 16'($urandom())};
    d2 = ~d1 & 32'hFFFF;
    wr(13'd80, d1);
    setx(4, d1[15:0]);
    run_pass();
    setx(5, 16'h1);
    setx(6, 16'h1);
    run_pass();
    pool(24, d1);
    pool(30, d1);
    pool(26, {31'h0, d1 == 0});
    pool(28, 32'h1);
    pool(29, 32'h0);
    setx(4, d2[15:0]);
    setx(7, 16'h1);
    run_pass();
    pool(24, d1);
    pool(28, 32'h0);
    pool(29, 32'h1);
    repeat (5) @(posedge clk);
    if (rdQ.size() != 0 || wrQ.size() != 0) n_fail++;
    close_out();
  end
endmodule
bind clge_engine clge_engine_asserts #(.PLC_CYCLE_CLKS(PLC_CYCLE_CLKS))
  u_chk (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready);
